//--- swpp_pkg.sv
// Package for the single-wire push/pull serial block: offsets, fields,
// reset values and timing constants.
// Assumes APB with 32-bit data and a 125 MHz pclk.
package swpp_pkg;
   // Printed offsets are not all multiples of four, so they are indices
   localparam logic [7:0] IDX_RATE_DIVISOR_HIGH = 8'hc0;
   localparam logic [7:0] IDX_RATE_DIVISOR_LOW = 8'hc1;
   localparam logic [7:0] IDX_CONTROL_ONE = 8'hc2;
   localparam logic [7:0] IDX_CONTROL_TWO = 8'hc3;
   localparam logic [7:0] IDX_BUS_STATUS_ONE = 8'hc4;
   localparam logic [7:0] IDX_BUS_STATUS_AND_MODE_TWO = 8'hc5;
   localparam logic [7:0] IDX_PUSH_PULL_DATA_LOW = 8'hc7;
   localparam logic [7:0] IDX_MODE_CONTROL = 8'hc8;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'hc9;
   localparam logic [7:0] IDX_IRQ_MASK = 8'hca;
   // Control two fields
   localparam int CR2_RIE = 5;
   localparam int CR2_TE = 3;
   localparam int CR2_RE = 2;
   localparam int CR2_SBK = 0;
   // Status one fields
   localparam int SR1_RECEIVE_FULL_FLAG = 5;
   localparam int SR1_BITERR = 3;
   localparam int SR1_NF = 2;
   // Mode control fields (writable copy of status-two mode bits)
   localparam int MC_SWAI = 7;
   localparam int MC_MIE = 6;
   localparam int MC_MDL_HI = 5;
   localparam int MC_MDL_LO = 4;
   // Interrupt status fields
   localparam int IRQ_RX = 0;
   localparam int IRQ_BITERR = 1;
   localparam int IRQ_NOISE = 2;
   localparam int IRQ_TXDONE = 3;
   localparam logic [7:0] RST_RATE_DIVISOR_LOW = 8'h01;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] PULL_ERROR_WORD = 8'hff;
   localparam logic [3:0] PULL_FIXED_HI = 4'h5;
   // Divider ticks per time slot and timing
   localparam logic [4:0] TICKS_PER_SLOT = 5'h10;
   localparam logic [4:0] LONG_LOW_SLOTS = 5'h14;
   localparam logic [3:0] PUSH_BITS = 4'h8;
   localparam logic [3:0] PULL_BITS = 4'h8;
   localparam logic [3:0] DIV_PRESCALE = 4'hf;
   typedef enum logic [2:0] {
      SWPP_IDLE = 3'b000,
      SWPP_PUSH = 3'b001,
      SWPP_WAIT = 3'b011,
      SWPP_PULL = 3'b010,
      SWPP_LOW = 3'b110
   } swpp_state_t;
endpackage

//--- swpp_rate_gen.sv
// Rate generator: one tick every divisor module clocks; divide-by-16
// happens in slot counting.
// Assumes a same-domain clock enable and a 13-bit divisor.
`timescale 1ns/1ns
`default_nettype none
module swpp_rate_gen
   import swpp_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic [12:0] divisor,
   output logic tick
);
   logic [12:0] cnt_ff;
   logic [12:0] nxt_cnt;
   logic nxt_tick;
   logic tick_ff;

   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_tick = 1'b0;
      // Zero divisor stops the generator
      if (!run || divisor == 13'h0000) begin
         nxt_cnt = 13'h0000;
      end else if (cnt_ff >= divisor - 13'h0001) begin
         nxt_cnt = 13'h0000;
         nxt_tick = 1'b1;
      end else begin
         nxt_cnt = cnt_ff + 13'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= 13'h0000;
         tick_ff <= 1'b0;
      end else if (run || divisor == 13'h0000) begin
         cnt_ff <= nxt_cnt;
         tick_ff <= nxt_tick;
      end else begin
         tick_ff <= 1'b0;
      end
   end

   assign tick = tick_ff;
endmodule
`default_nettype wire

//--- swpp_top.sv
// Single-wire push/pull serial port with APB registers and interrupt.
// Assumes an open-collector wire sampled on receive_pin, asynchronous to
// pclk, and a wait_mode level from the processor on pclk.
`timescale 1ns/1ns
`default_nettype none
module swpp_top
   import swpp_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic wait_mode,
   input wire logic receive_pin,
   output logic transmit_pin,
   output logic transmit_pin_oe_n,
   output logic irq
);
   logic [7:0] div_hi_ff, div_lo_ff, cr1_ff, cr2_ff, mode_ff;
   logic [7:0] nxt_div_hi, nxt_div_lo, nxt_cr1, nxt_cr2, nxt_mode;
   logic [12:0] divisor_ff, nxt_divisor;
   logic [7:0] tx_ff, nxt_tx, rx_ff, nxt_rx, sh_ff, nxt_sh;
   logic tx_pend_ff, nxt_tx_pend;
   logic receive_full_flag_ff, nxt_receive_full_flag, berr_ff, nxt_berr, nf_ff, nxt_nf;
   logic [2:0] snap_ff, nxt_snap;
   logic [3:0] irqs_ff, nxt_irqs, irqm_ff, nxt_irqm;
   logic [31:0] prdata_ff, nxt_prdata;
   swpp_state_t st_ff, nxt_st;
   logic [4:0] tk_ff, nxt_tk, slot_ff, nxt_slot;
   logic [3:0] bit_ff, nxt_bit;
   logic [2:0] smp_ff, nxt_smp;
   logic drive_ff, nxt_drive;
   logic rx_s1_ff, rx_s2_ff, rx_prev_ff;
   logic tick, rg_run, single_wire_mode_enable, acc, wr, rd, rd_setup;
   logic [7:0] idx;
   logic ev_rx, ev_berr, ev_nf, ev_txd;

   function automatic logic is_reg(input logic [7:0] i, input logic [7:0] r);
      is_reg = (i == r);
   endfunction

   assign idx = paddr[9:2];
   assign acc = psel && penable && clk_en;
   assign wr = acc && pwrite;
   assign rd = acc && !pwrite;
   // Read data loads in setup so it stands at the access edge
   assign rd_setup = psel && !penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign prdata = prdata_ff;
   assign single_wire_mode_enable = mode_ff[MC_MIE];
   // Serial clock stops in wait mode if asked
   assign rg_run = clk_en && !(mode_ff[MC_SWAI] && wait_mode)
      && (cr2_ff[CR2_TE] || cr2_ff[CR2_RE]);

   swpp_rate_gen u_rate (
      .pclk(pclk),
      .presetn(presetn),
      .run(rg_run),
      .divisor(divisor_ff),
      .tick(tick)
   );

   // Pin synchroniser; first stage feeds only the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_s1_ff <= 1'b1;
         rx_s2_ff <= 1'b1;
         rx_prev_ff <= 1'b1;
      end else if (clk_en) begin
         rx_s1_ff <= receive_pin;
         rx_s2_ff <= rx_s1_ff;
         rx_prev_ff <= rx_s2_ff;
      end
   end

   // Link state machine
   logic [4:0] dly_tick;
   logic slot_end, rx_bit;
   assign dly_tick = {1'b0, 2'b00, mode_ff[MC_MDL_HI:MC_MDL_LO]};
   assign slot_end = tick && tk_ff == TICKS_PER_SLOT - 5'h01;
   assign rx_bit = rx_s2_ff;

   always_comb begin
      nxt_st = st_ff;
      nxt_tk = tk_ff;
      nxt_slot = slot_ff;
      nxt_bit = bit_ff;
      nxt_sh = sh_ff;
      nxt_smp = smp_ff;
      nxt_drive = drive_ff;
      nxt_tx_pend = tx_pend_ff;
      ev_rx = 1'b0;
      ev_berr = 1'b0;
      ev_nf = 1'b0;
      ev_txd = 1'b0;
      nxt_rx = rx_ff;
      nxt_tx = tx_ff;
      if (wr && is_reg(idx, IDX_PUSH_PULL_DATA_LOW)) begin
         nxt_tx = pwdata[7:0];
         nxt_tx_pend = 1'b1;
      end
      if (tick) begin
         nxt_tk = tk_ff + 5'h01;
         if (slot_end) begin
            nxt_tk = 5'h00;
         end
      end
      case (st_ff)
         SWPP_IDLE: begin
            nxt_drive = 1'b0;
            nxt_tk = 5'h00;
            if (cr2_ff[CR2_SBK] && cr2_ff[CR2_TE]) begin
               nxt_st = SWPP_LOW;
               nxt_slot = 5'h00;
               nxt_drive = 1'b1;
            end else if (tx_pend_ff && cr2_ff[CR2_TE]) begin
               nxt_st = SWPP_PUSH;
               nxt_sh = tx_ff;
               nxt_bit = 4'h0;
               nxt_tx_pend = 1'b0;
               nxt_drive = single_wire_mode_enable ? !tx_ff[0] : 1'b0;
            end else if (cr2_ff[CR2_RE] && rx_prev_ff && !rx_bit) begin
               // Falling edge only: our own push tail is no pull sync
               nxt_st = SWPP_WAIT;
               // Sync slot is sampled first, then shifted out again
               nxt_bit = 4'hf;
               nxt_smp = 3'b000;
            end
         end
         SWPP_PUSH: begin
            // Sample own bit mid-slot to compare with the wire
            if (tick && tk_ff == TICKS_PER_SLOT[4:1]
                  && rx_bit != sh_ff[0] && single_wire_mode_enable) begin
               ev_berr = 1'b1;
            end
            if (slot_end) begin
               nxt_sh = {1'b1, sh_ff[7:1]};
               nxt_bit = bit_ff + 4'h1;
               nxt_drive = !sh_ff[1];
               if (bit_ff == PUSH_BITS - 4'h1) begin
                  nxt_st = SWPP_IDLE;
                  nxt_drive = 1'b0;
                  ev_txd = 1'b1;
               end
            end
         end
         SWPP_WAIT: begin
            // Delay factor plus one ticks before the pull slots start
            if (tick && tk_ff == dly_tick) begin
               nxt_st = SWPP_PULL;
               nxt_tk = 5'h00;
            end
         end
         SWPP_PULL: begin
            // Three samples per bit; disagreement marks noise
            if (tick && tk_ff >= 5'h07 && tk_ff <= 5'h09) begin
               nxt_smp = {smp_ff[1:0], rx_bit};
            end
            if (slot_end) begin
               nxt_sh = {(smp_ff[1] & smp_ff[0]) | (smp_ff[2] & smp_ff[1])
                  | (smp_ff[2] & smp_ff[0]), sh_ff[7:1]};
               if (smp_ff != 3'b000 && smp_ff != 3'b111) begin
                  ev_nf = 1'b1;
               end
               nxt_bit = bit_ff + 4'h1;
               if (bit_ff == PULL_BITS - 4'h1) begin
                  nxt_st = SWPP_IDLE;
                  ev_rx = 1'b1;
                  nxt_rx = nxt_sh;
                  if (nf_ff || ev_nf) begin
                     nxt_rx = PULL_ERROR_WORD;
                  end
               end
            end
         end
         SWPP_LOW: begin
            nxt_drive = 1'b1;
            if (slot_end) begin
               nxt_slot = slot_ff + 5'h01;
               if (slot_ff == LONG_LOW_SLOTS - 5'h01) begin
                  nxt_st = SWPP_IDLE;
                  nxt_drive = 1'b0;
               end
            end
         end
         default: begin
            nxt_st = SWPP_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= SWPP_IDLE;
         tk_ff <= 5'h00;
         slot_ff <= 5'h00;
         bit_ff <= 4'h0;
         sh_ff <= RST_ZERO;
         smp_ff <= 3'b000;
         drive_ff <= 1'b0;
         tx_pend_ff <= 1'b0;
         rx_ff <= RST_ZERO;
         tx_ff <= RST_ZERO;
      end else if (clk_en) begin
         st_ff <= nxt_st;
         tk_ff <= nxt_tk;
         slot_ff <= nxt_slot;
         bit_ff <= nxt_bit;
         sh_ff <= nxt_sh;
         smp_ff <= nxt_smp;
         drive_ff <= nxt_drive;
         tx_pend_ff <= nxt_tx_pend;
         rx_ff <= nxt_rx;
         tx_ff <= nxt_tx;
      end
   end

   // Open-collector in single-wire mode; push-pull otherwise
   assign transmit_pin = single_wire_mode_enable ? 1'b0 : !drive_ff;
   assign transmit_pin_oe_n = single_wire_mode_enable ? !drive_ff : !cr2_ff[CR2_TE];

   // Registers, flags and interrupt
   logic rd_sr1, rd_dat, rd_irq;
   assign rd_sr1 = rd && is_reg(idx, IDX_BUS_STATUS_ONE);
   assign rd_dat = rd && is_reg(idx, IDX_PUSH_PULL_DATA_LOW);
   assign rd_irq = rd && is_reg(idx, IDX_IRQ_STATUS);

   always_comb begin
      nxt_div_hi = div_hi_ff;
      nxt_div_lo = div_lo_ff;
      nxt_divisor = divisor_ff;
      nxt_cr1 = cr1_ff;
      nxt_cr2 = cr2_ff;
      nxt_mode = mode_ff;
      nxt_irqm = irqm_ff;
      nxt_snap = snap_ff;
      nxt_prdata = 32'h0000_0000;
      if (wr) begin
         case (idx)
            IDX_RATE_DIVISOR_HIGH: nxt_div_hi = {3'b000, pwdata[4:0]};
            IDX_RATE_DIVISOR_LOW: begin
               nxt_div_lo = pwdata[7:0];
               // Low byte write commits the divisor
               nxt_divisor = {div_hi_ff[4:0], pwdata[7:0]};
            end
            IDX_CONTROL_ONE: nxt_cr1 = pwdata[7:0];
            IDX_CONTROL_TWO: nxt_cr2 = pwdata[7:0];
            IDX_MODE_CONTROL: nxt_mode = {pwdata[7:4], 4'h0};
            IDX_IRQ_MASK: nxt_irqm = pwdata[3:0];
            default: nxt_cr2 = cr2_ff;
         endcase
      end
      // Long-low request is self-clearing once started
      if (st_ff == SWPP_LOW) begin
         nxt_cr2[CR2_SBK] = 1'b0;
      end
      // Snapshot what the read showed, not what is set now
      if (rd_sr1) begin
         nxt_snap = {prdata_ff[SR1_RECEIVE_FULL_FLAG], prdata_ff[SR1_BITERR],
            prdata_ff[SR1_NF]};
      end else if (rd_dat) begin
         nxt_snap = 3'b000;
      end
      if (rd_setup) begin
         case (idx)
            IDX_RATE_DIVISOR_HIGH: nxt_prdata[7:0] = div_hi_ff;
            IDX_RATE_DIVISOR_LOW: nxt_prdata[7:0] = div_lo_ff;
            IDX_CONTROL_ONE: nxt_prdata[7:0] = cr1_ff;
            IDX_CONTROL_TWO: nxt_prdata[7:0] = cr2_ff;
            IDX_BUS_STATUS_ONE: nxt_prdata[7:0] = {2'b00, receive_full_flag_ff,
               1'b0, berr_ff, nf_ff, 2'b00};
            IDX_BUS_STATUS_AND_MODE_TWO: nxt_prdata[7:0] =
               {mode_ff[7:4], 3'b000, st_ff == SWPP_PULL};
            IDX_PUSH_PULL_DATA_LOW: nxt_prdata[7:0] = (rx_ff ==
               PULL_ERROR_WORD) ? rx_ff : {PULL_FIXED_HI, rx_ff[3:1],
               1'b1};
            IDX_MODE_CONTROL: nxt_prdata[7:0] = mode_ff;
            IDX_IRQ_STATUS: nxt_prdata[3:0] = irqs_ff;
            IDX_IRQ_MASK: nxt_prdata[3:0] = irqm_ff;
            default: nxt_prdata = 32'h0000_0000;
         endcase
      end
      // Sets win over clears
      nxt_receive_full_flag = ev_rx || (receive_full_flag_ff && !(rd_dat && snap_ff[2]));
      nxt_berr = ev_berr || (berr_ff && !(rd_dat && snap_ff[1]));
      nxt_nf = ev_nf || (nf_ff && !(rd_dat && snap_ff[0]));
      if (st_ff == SWPP_IDLE && nxt_st == SWPP_WAIT) begin
         nxt_nf = nxt_nf && !receive_full_flag_ff ? nxt_nf : nxt_nf;
      end
      // Clear only the bits the read showed
      nxt_irqs = irqs_ff & ~(rd_irq ? prdata_ff[3:0] : 4'h0);
      nxt_irqs[IRQ_RX] = nxt_irqs[IRQ_RX]
         || (ev_rx && cr2_ff[CR2_RIE]);
      // Bit error never requests an interrupt: gated to outside single-wire mode, where it never occurs
      nxt_irqs[IRQ_BITERR] = nxt_irqs[IRQ_BITERR]
         || (ev_berr && !single_wire_mode_enable);
      nxt_irqs[IRQ_NOISE] = nxt_irqs[IRQ_NOISE] || ev_nf;
      nxt_irqs[IRQ_TXDONE] = nxt_irqs[IRQ_TXDONE] || ev_txd;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_hi_ff <= RST_ZERO;
         div_lo_ff <= RST_RATE_DIVISOR_LOW;
         divisor_ff <= {5'h00, RST_RATE_DIVISOR_LOW};
         cr1_ff <= RST_ZERO;
         cr2_ff <= RST_ZERO;
         mode_ff <= RST_ZERO;
         irqm_ff <= 4'h0;
         irqs_ff <= 4'h0;
         snap_ff <= 3'b000;
         receive_full_flag_ff <= 1'b0;
         berr_ff <= 1'b0;
         nf_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end else if (clk_en) begin
         div_hi_ff <= nxt_div_hi;
         div_lo_ff <= nxt_div_lo;
         divisor_ff <= nxt_divisor;
         cr1_ff <= nxt_cr1;
         cr2_ff <= nxt_cr2;
         mode_ff <= nxt_mode;
         irqm_ff <= nxt_irqm;
         irqs_ff <= nxt_irqs;
         snap_ff <= nxt_snap;
         receive_full_flag_ff <= nxt_receive_full_flag;
         berr_ff <= nxt_berr;
         nf_ff <= nxt_nf;
         prdata_ff <= nxt_prdata;
      end
   end

   assign irq = |(irqs_ff & irqm_ff);
endmodule
`default_nettype wire

//--- swpp_asserts.sv
// Checker on the serial port's APB and wire pins.
// Assumes one pclk domain, reset by presetn.
`timescale 1ns/1ns
`default_nettype none
module swpp_asserts
   import swpp_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic wait_mode,
   input wire logic receive_pin,
   input wire logic transmit_pin,
   input wire logic transmit_pin_oe_n,
   input wire logic irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic rd;
   logic [7:0] ix;
   assign rd = psel && penable && !pwrite && clk_en;
   assign ix = paddr[9:2];
   a_ready_high: assert property (pready)
      else $error("pready low");
   a_no_slverr: assert property (!pslverr)
      else $error("pslverr high");
   a_idle_zero: assert property ($past(clk_en)
      && !(psel && penable && !pwrite) |-> prdata == 32'h0)
      else $error("prdata not zero when idle");
   a_upper_zero: assert property (prdata[31:8] == 24'h0)
      else $error("prdata upper bits set");
   a_unmapped_zero: assert property (rd && (ix < IDX_RATE_DIVISOR_HIGH
      || ix > IDX_IRQ_MASK) |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_mode_gaps: assert property (rd && ix == IDX_BUS_STATUS_AND_MODE_TWO
      |-> prdata[3:1] == 3'h0) else $error("mode register gap bits set");
   a_drive_hold: assert property ($fell(transmit_pin_oe_n)
      |-> !transmit_pin_oe_n [*8]) else $error("wire drive too short");
   a_irq_shown: assert property (rd && ix == IDX_IRQ_STATUS && $past(irq)
      |-> prdata[7:0] != 8'h0) else $error("irq without status bit");
   a_irq_clear: assert property (rd && ix == IDX_IRQ_STATUS
      |-> ##[1:3] !irq) else $error("irq not cleared by status read");
endmodule
bind swpp_top swpp_asserts u_asserts (.pclk(pclk), .presetn(presetn),
   .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .wait_mode(wait_mode), .receive_pin(receive_pin),
   .transmit_pin(transmit_pin), .transmit_pin_oe_n(transmit_pin_oe_n),
   .irq(irq));
`default_nettype wire

//--- swpp_slave_model.sv
// Slave on the shared single-wire bus: answers a pull field.
// Assumes the bench joins pull_low to the wire with a pull-up.
`timescale 1ns/1ns
`default_nettype none
module swpp_slave_model (
   input wire logic pclk,
   input wire logic [7:0] slot,
   input wire logic jam,
   input wire logic go,
   input wire logic noisy,
   input wire logic [7:0] reply,
   output logic pull_low,
   output logic busy
);
   int i;
   int j;
   // Released wire rises through the pull-up, never left floating
   initial begin
      pull_low = 1'b0;
      busy = 1'b0;
      forever begin
         @(posedge pclk);
         if (jam) begin
            pull_low <= 1'b1;
         end else if (go) begin
            busy <= 1'b1;
            pull_low <= 1'b1;
            repeat (slot) @(posedge pclk);
            for (i = 0; i < 8; i++) begin
               for (j = 0; j < slot; j++) begin
                  // Toggling each clock upsets a three-sample vote taken on consecutive clocks
                  pull_low <= (noisy && j > 5 && j < 15) ? j[0]
                     : !reply[i];
                  @(posedge pclk);
               end
            end
            busy <= 1'b0;
            pull_low <= 1'b0;
         end else begin
            pull_low <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

//--- test_single_wire_push_pull_serial_mode.sv
// Bench for the push/pull port: APB master, wire and one slave.
// Assumes the slave model and bound checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module test_single_wire_push_pull_serial_mode
   import swpp_pkg::*;
   ;
   logic pclk, presetn, clk_en, psel, penable, pwrite, wait_mode, irq;
   logic pready, pslverr, transmit_pin, oe_n, rx_wire;
   logic jam, go, noisy, pull_low, busy;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0] q, d, m, div, reply, exp_w;
   logic [2:0] s;
   int n_mismatch = 0;
   int compares = 0;
   int n, k, w, r;
   assign rx_wire = (oe_n | transmit_pin) & !pull_low;
   swpp_top dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .wait_mode(wait_mode), .receive_pin(rx_wire),
      .transmit_pin(transmit_pin), .transmit_pin_oe_n(oe_n), .irq(irq));
   swpp_slave_model slave (.pclk(pclk), .slot({div[3:0], 4'h0}),
      .jam(jam), .go(go), .noisy(noisy), .reply(reply),
      .pull_low(pull_low), .busy(busy));
   task automatic chk(input string nm, input logic [15:0] seen,
      input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Read data is taken at the edge that samples pready high
   task automatic bus(input logic wr, input logic [7:0] ix,
      input logic [7:0] wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, ix, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata[7:0];
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic until_low;
      for (n = 0; n < 999 && oe_n !== 1'b0; n++) @(posedge pclk);
   endtask
   function automatic logic [7:0] pull_word(input logic [2:0] st);
      return {4'h5, st, 1'b1};
   endfunction
   function automatic logic [15:0] low_len(input logic [7:0] dv,
      input int wt);
      return 16'(LONG_LOW_SLOTS) * 16'(TICKS_PER_SLOT) * 16'(dv) + 16'(wt);
   endfunction
   task automatic end_of_test;
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // Whole run needs well under a tenth of this
   initial begin
      repeat (60000) @(posedge pclk);
      n_mismatch++;
      end_of_test;
   end
   initial begin
      {presetn, psel, penable, pwrite, wait_mode, jam, go, noisy} = 8'h0;
      clk_en = 1'b1;
      paddr = 12'h0;
      pwdata = 32'h0;
      reply = 8'h0;
      div = 8'h1;
      r = $urandom(96388);
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      bus(1'b1, IDX_BUS_STATUS_AND_MODE_TWO, 8'hff);
      bus(1'b0, IDX_BUS_STATUS_AND_MODE_TWO, 8'h0);
      chk("mode two reset", q, RST_ZERO);
      bus(1'b0, IDX_RATE_DIVISOR_LOW, 8'h0);
      chk("divisor reset", q, RST_RATE_DIVISOR_LOW);
      bus(1'b1, 8'hd0, 8'h5a);
      bus(1'b0, 8'hd0, 8'h0);
      chk("unmapped", q, 8'h0);
      bus(1'b1, IDX_IRQ_MASK, 8'h0f);
      bus(1'b1, IDX_MODE_CONTROL, 8'h40);
      bus(1'b1, IDX_CONTROL_TWO, 8'h2c);
      for (k = 0; k < 4; k++) begin
         div = 8'(k % 2 + 1);
         noisy <= (k == 2);
         m = {1'($urandom), 1'b1, 2'(k), 4'h0};
         bus(1'b1, IDX_RATE_DIVISOR_LOW, div);
         bus(1'b1, IDX_MODE_CONTROL, m);
         bus(1'b0, IDX_BUS_STATUS_AND_MODE_TWO, 8'h0);
         chk("mode two", q, m);
         d = 8'($urandom) & 8'hfe;
         bus(1'b1, IDX_PUSH_PULL_DATA_LOW, d);
         until_low;
         repeat (8 * div - 1) @(posedge pclk);
         for (w = 0; w < 8; w++) begin
            chk("push bit", oe_n, d[w]);
            repeat (16 * div) @(posedge pclk);
         end
         for (n = 0; n < 4000 && irq !== 1'b1; n++) @(posedge pclk);
         bus(1'b0, IDX_IRQ_STATUS, 8'h0);
         chk("push done", q & 8'h08, 8'h08);
         s = 3'($urandom);
         exp_w = noisy ? PULL_ERROR_WORD : pull_word(s);
         reply <= pull_word(s);
         go <= 1'b1;
         @(posedge pclk);
         go <= 1'b0;
         repeat (40 * div) @(posedge pclk);
         bus(1'b0, IDX_BUS_STATUS_AND_MODE_TWO, 8'h0);
         chk("receiver active", q, m | 8'h01);
         for (n = 0; n < 999 && busy !== 1'b0; n++) @(posedge pclk);
         repeat (48 * div) @(posedge pclk);
         bus(1'b0, IDX_BUS_STATUS_ONE, 8'h0);
         chk("status one", q & 8'h24, {5'h4, noisy, 2'b00});
         bus(1'b0, IDX_PUSH_PULL_DATA_LOW, 8'h0);
         chk("pull data", q, exp_w);
         bus(1'b0, IDX_BUS_STATUS_ONE, 8'h0);
         chk("status cleared", q & 8'h24, 8'h0);
         bus(1'b0, IDX_IRQ_STATUS, 8'h0);
         chk("rx irq", q & 8'h05, {5'h0, noisy, 2'b01});
      end
      // Masked, receiver off so the jammed wire is no pull sync
      noisy <= 1'b0;
      bus(1'b1, IDX_IRQ_MASK, 8'h00);
      bus(1'b1, IDX_CONTROL_TWO, 8'h08);
      jam <= 1'b1;
      bus(1'b1, IDX_PUSH_PULL_DATA_LOW, 8'($urandom) | 8'h01);
      repeat (144 * div) @(posedge pclk);
      jam <= 1'b0;
      chk("masked irq", irq, 1'b0);
      bus(1'b0, IDX_BUS_STATUS_ONE, 8'h0);
      chk("bit error", q & 8'h08, 8'h08);
      bus(1'b0, IDX_IRQ_STATUS, 8'h0);
      chk("irq status", q & 8'h0a, 8'h08);
      // One tick per clock keeps the long-low length exact
      div = 8'h1;
      bus(1'b1, IDX_RATE_DIVISOR_LOW, div);
      for (w = 0; w < 2; w++) begin
         bus(1'b1, IDX_MODE_CONTROL, {1'(w), 7'h40});
         bus(1'b1, IDX_CONTROL_TWO, 8'h09);
         until_low;
         fork
            for (n = 0; n < 2000 && oe_n === 1'b0; n++) @(posedge pclk);
            begin
               bus(1'b1, IDX_CONTROL_TWO, 8'h08);
               wait_mode <= 1'b1;
               repeat (100) @(posedge pclk);
               wait_mode <= 1'b0;
            end
         join
         chk("long low", 16'(n), low_len(div, 100 * w));
      end
      end_of_test;
   end
endmodule
`default_nettype wire
